// file: dv/tb_vlcc_coupler.sv
`timescale 1ns/100ps
module tb_vlcc_coupler import vlcc_pkg::*;;
  logic clk = 0, reset = 1, release_on_request = 0, arbiter_bypass = 0, fifo_coupled = 1;
  logic rx_fifo_enable = 0, local_addr_strobe_n = 1, vme_target_select_n = 1, local_write = 0;
  logic local_iack = 0, local_other_request_n = 1, vme_bus_clear_n = 1, vme_slave_as_n = 1;
  logic vme_slave_ds_n = 1, vme_slave_select = 0, vme_slave_write = 0, iack_in_n = 1;
  logic rx_ready = 0, dec = 0;
  logic [1:0] request_level = 2'h0;
  logic [3:0] oth_n = 4'hF;
  logic [31:0] local_addr = 32'h0, local_wdata = 32'h0, vme_slave_addr = 32'h0;
  logic [31:0] vme_slave_wdata = 32'h0, a, d, e, f;
  logic local_data_ack_n, local_bus_request_n, local_bus_grant_n, local_other_grant_n;
  logic local_master_as_n, local_master_write, local_master_ack_n, vme_bus_busy_n;
  logic vme_addr_strobe_pin_n, vme_data_strobe_pin_n, vme_write, vme_dtack_n;
  logic vme_slave_dtack_n, iack_out_n, rx_valid;
  logic [3:0] vme_bus_request_n, vme_bus_grant_in_n, vme_bus_grant_out_n;
  logic [31:0] local_rdata, local_master_addr, local_master_wdata, local_master_rdata;
  logic [31:0] vme_addr, vme_wdata, vme_rdata, vme_slave_rdata, rx_addr, rx_data;
  int n_fail = 0, samples_checked = 0, seed = 32'h4D14, cyc = 0;
  int t, t1, t2, ta, tv, tp = 0, nreq = 0, n;
  int ts[2];
  logic [31:0] q[$];
  vlcc_coupler u_vlcc_coupler (.*);
  vlcc_far u_vlcc_far (.*);
  always #5 clk = ~clk;
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      n_fail++;
      end_sim();
    end
  end
  task automatic chk(string nm, logic [31:0] seen, logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      n_fail++;
      $display("ERROR %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic end_sim();
    $display("checks %0d errors %0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  task automatic wt(ref logic s, input logic v, input int lim);
    t = 0;
    while (s !== v && t < lim) begin
      @(negedge clk);
      t++;
    end
    if (lim > 30) chk("wait_limit", t < lim, 1);
  endtask
  task automatic lcyc(logic w, logic [31:0] ad, dd);
    @(negedge clk);
    local_write = w;
    local_addr = ad;
    local_wdata = dd;
    local_addr_strobe_n = 0;
    vme_target_select_n = 0;
    t1 = cyc;
    wt(local_data_ack_n, 0, 400);
    ta = cyc - t1;
    if (!w) chk("local_rdata", local_rdata, ad ^ 32'h5A5A_5A5A);
    local_addr_strobe_n = 1;
    vme_target_select_n = 1;
    local_addr = ~ad;
    local_wdata = ~dd;
    wt(local_data_ack_n, 1, 400);
  endtask
  task automatic sgo(logic w, logic [31:0] ad, dd, int lim);
    @(negedge clk);
    vme_slave_write = w;
    vme_slave_addr = ad;
    vme_slave_wdata = dd;
    vme_slave_select = 1;
    vme_slave_as_n = 0;
    vme_slave_ds_n = 0;
    wt(vme_slave_dtack_n, 0, lim);
    chk("local_req_off", local_bus_request_n, 1);
  endtask
  task automatic srel();
    vme_slave_as_n = 1;
    vme_slave_ds_n = 1;
    vme_slave_select = 0;
    vme_slave_addr = ~vme_slave_addr;
    vme_slave_wdata = ~vme_slave_wdata;
    wt(vme_slave_dtack_n, 1, 400);
  endtask
  always @(negedge vme_bus_request_n[0]) nreq++;
  // Look after the launching edge has settled every output
  always @(negedge vme_addr_strobe_pin_n) begin
    #1;
    tv = cyc - t1;
    chk("vme_ds", vme_data_strobe_pin_n, 0);
    chk("vme_write", vme_write, dec);
    if (dec) begin
      e = q.pop_front();
      chk("vme_wdata", vme_wdata, e);
      chk("vme_addr", vme_addr, ~e);
      if (tp > 0) chk("strobe_gap", 32'(cyc - tp > 10), 32'h1);
      tp = cyc;
    end
  end
  always @(negedge clk) #1 if (rx_valid && rx_ready) begin
    f = q.pop_front();
    chk("rx_data", rx_data, f);
    chk("rx_addr", rx_addr, ~f);
  end
  always @(negedge local_master_as_n) #1 begin
    chk("lm_addr", local_master_addr, vme_slave_addr);
    chk("lm_data", local_master_wdata, vme_slave_wdata);
    chk("lm_write", local_master_write, vme_slave_write);
  end
  initial begin
    repeat (8) @(negedge clk);
    reset = 0;
    oth_n = 4'h5;
    repeat (4) @(negedge clk);
    chk("grant_pass", vme_bus_grant_out_n[3:1], oth_n[3:1]);
    chk("idle_acks", {local_data_ack_n, vme_slave_dtack_n, vme_bus_busy_n}, 3'h7);
    chk("idle_outs", {rx_valid, iack_out_n, local_bus_request_n}, 3'h3);
    for (int i = 0; i < 2; i++) begin
      local_iack = i[0];
      lcyc(0, $random(seed), 32'h0);
      repeat (12) @(negedge clk);
      chk("busy_rwd", vme_bus_busy_n, 1);
    end
    t2 = tv;
    local_iack = 0;
    release_on_request = 1;
    lcyc(0, $random(seed), 32'h0);
    lcyc(0, $random(seed), 32'h0);
    chk("busy_ror", vme_bus_busy_n, 0);
    chk("ror_faster", tv < t2, 1);
    vme_bus_clear_n = 0;
    repeat (20) @(negedge clk);
    chk("busy_clear", vme_bus_busy_n, 1);
    vme_bus_clear_n = 1;
    fifo_coupled = 0;
    dec = 1;
    n = nreq;
    for (int i = 0; i < 6; i++) begin
      d = $random(seed);
      q.push_back(d);
      lcyc(1, ~d, d);
    end
    fifo_coupled = 1;
    d = $random(seed);
    q.push_back(d);
    lcyc(1, ~d, d);
    chk("coupled_wait", tv < ta, 1);
    chk("one_arbitration", nreq - n, 1);
    dec = 0;
    for (int i = 0; i < 2; i++) begin
      arbiter_bypass = i[0];
      repeat (3) @(negedge clk);
      a = $random(seed);
      sgo(0, a, 32'h0, 400);
      chk("vme_slave_rdata", vme_slave_rdata, a ^ 32'h0F0F_0F0F);
      ts[i] = t;
      srel();
      sgo(1, a, $random(seed), 400);
      chk("rw_equal", t <= ts[i] + 3 && t + 3 >= ts[i], 1);
      srel();
    end
    chk("arbiter_slower", ts[0] > ts[1], 1);
    arbiter_bypass = 0;
    local_other_request_n = 0;
    repeat (6) @(negedge clk);
    chk("other_grant", local_other_grant_n, 0);
    local_other_request_n = 1;
    repeat (6) @(negedge clk);
    chk("other_free", local_other_grant_n, 1);
    rx_fifo_enable = 1;
    n = 0;
    do begin
      d = $random(seed);
      q.push_back(d);
      sgo(1, ~d, d, 30);
      if (t < 30) begin
        chk("rx_ack_time", t <= RX_ACK_CYC, 1);
        srel();
      end
      n++;
    end while (t < 30 && n < 6);
    chk("rx_refused", t, 30);
    rx_ready = 1;
    wt(vme_slave_dtack_n, 0, 400);
    srel();
    repeat (10) @(negedge clk);
    chk("rx_empty", rx_valid, 0);
    chk("rx_all", q.size(), 0);
    iack_in_n = 0;
    @(negedge clk);
    chk("iack_early", iack_out_n, 1);
    repeat (12) @(negedge clk);
    chk("iack_out", iack_out_n, 0);
    end_sim();
  end
endmodule

// file: dv/vlcc_far.sv
`timescale 1ns/100ps
module vlcc_far import vlcc_pkg::*; (
  input wire logic clk,
  input wire logic [3:0] vme_bus_request_n,
  input wire logic [3:0] oth_n,
  output logic [3:0] vme_bus_grant_in_n,
  input wire logic vme_addr_strobe_pin_n,
  input wire logic [AW-1:0] vme_addr,
  output logic vme_dtack_n = 1'b1,
  output logic [DW-1:0] vme_rdata,
  input wire logic local_bus_request_n,
  output logic local_bus_grant_n = 1'b1,
  input wire logic local_master_as_n,
  input wire logic [AW-1:0] local_master_addr,
  output logic local_master_ack_n = 1'b1,
  output logic [DW-1:0] local_master_rdata
);
  logic [3:0] rq = 4'hF;
  logic [2:0] w = 3'h0;
  assign vme_bus_grant_in_n = oth_n & rq;
  // Released lines show the inverse, never stale data
  assign vme_rdata = {DW{vme_dtack_n}} ^ vme_addr ^ 32'h5A5A_5A5A;
  assign local_master_rdata = {DW{local_master_ack_n}} ^ local_master_addr ^ 32'h0F0F_0F0F;
  always @(posedge clk) begin
    rq <= vme_bus_request_n;
    local_bus_grant_n <= local_bus_request_n & local_master_as_n;
    local_master_ack_n <= local_master_as_n;
    w <= vme_addr_strobe_pin_n ? 3'h0 : w + {2'h0, w != 3'h7};
    vme_dtack_n <= vme_addr_strobe_pin_n | (w < 3'h3);
  end
endmodule

// file: hdl/vlcc_buffer.sv
`timescale 1ns/100ps
module vlcc_buffer import vlcc_pkg::*; #(
  parameter int W = XW
) (
  input wire logic clk,
  input wire logic reset,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [W-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [W-1:0] out_data
);
  logic [W-1:0] mem_q [BUF_DEPTH];
  logic [W-1:0] mem_d [BUF_DEPTH];
  logic [1:0] cnt_q, cnt_d;
  logic rd_q, rd_d, wr_q, wr_d;
  logic push, pop;

  assign in_ready = (cnt_q != 2'(BUF_DEPTH));
  assign out_valid = (cnt_q != 2'h0);
  assign out_data = mem_q[rd_q];
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;

  always_comb begin
    mem_d = mem_q;
    if (push) begin
      mem_d[wr_q] = in_data;
    end
    wr_d = push ? !wr_q : wr_q;
    rd_d = pop ? !rd_q : rd_q;
    cnt_d = cnt_q + 2'(push) - 2'(pop);
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      cnt_q <= 2'h0;
      rd_q <= 1'b0;
      wr_q <= 1'b0;
    end else begin
      cnt_q <= cnt_d;
      rd_q <= rd_d;
      wr_q <= wr_d;
    end
    mem_q <= mem_d;
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);
  AST_BUF_NO_OVERFLOW: assert property (cnt_q <= 2'(BUF_DEPTH))
    else $error("buffer count out of range");
endmodule

// file: hdl/vlcc_coupler.sv
`timescale 1ns/100ps
module vlcc_coupler import vlcc_pkg::*; (
  input wire logic clk,
  input wire logic reset,
  input wire logic release_on_request,
  input wire logic arbiter_bypass,
  input wire logic fifo_coupled,
  input wire logic rx_fifo_enable,
  input wire logic [1:0] request_level,
  input wire logic local_addr_strobe_n,
  input wire logic vme_target_select_n,
  input wire logic local_write,
  input wire logic local_iack,
  input wire logic [AW-1:0] local_addr,
  input wire logic [DW-1:0] local_wdata,
  output logic local_data_ack_n,
  output logic [DW-1:0] local_rdata,
  output logic local_bus_request_n,
  input wire logic local_bus_grant_n,
  input wire logic local_other_request_n,
  output logic local_other_grant_n,
  output logic local_master_as_n,
  output logic local_master_write,
  output logic [AW-1:0] local_master_addr,
  output logic [DW-1:0] local_master_wdata,
  input wire logic local_master_ack_n,
  input wire logic [DW-1:0] local_master_rdata,
  output logic [3:0] vme_bus_request_n,
  input wire logic [3:0] vme_bus_grant_in_n,
  output logic [3:0] vme_bus_grant_out_n,
  input wire logic vme_bus_clear_n,
  output logic vme_bus_busy_n,
  output logic vme_addr_strobe_pin_n,
  output logic vme_data_strobe_pin_n,
  output logic vme_write,
  output logic [AW-1:0] vme_addr,
  output logic [DW-1:0] vme_wdata,
  input wire logic vme_dtack_n,
  input wire logic [DW-1:0] vme_rdata,
  input wire logic vme_slave_as_n,
  input wire logic vme_slave_ds_n,
  input wire logic vme_slave_select,
  input wire logic vme_slave_write,
  input wire logic [AW-1:0] vme_slave_addr,
  input wire logic [DW-1:0] vme_slave_wdata,
  output logic vme_slave_dtack_n,
  output logic [DW-1:0] vme_slave_rdata,
  input wire logic iack_in_n,
  output logic iack_out_n,
  output logic rx_valid,
  input wire logic rx_ready,
  output logic [AW-1:0] rx_addr,
  output logic [DW-1:0] rx_data
);
  function automatic logic [3:0] sat_inc(logic [3:0] v, logic en);
    return (en && v != 4'hF) ? v + 4'h1 : v;
  endfunction

  // Every pin but reset, rx_ready and the other levels of vme_bus_grant_in_n passes two flops; wide buses settle while their strobe is held
  logic [SYNC_W-1:0] sync1_q, sync2_q;
  logic s_las_n, s_vsel_n, s_lwrite, s_liack, s_lbg_n, s_oreq_n, s_lmack_n;
  logic s_bclr_n, s_dtack_n, s_vas_n, s_vds_n, s_vsel, s_vwrite;
  logic s_ror, s_byp, s_fcpl, s_rxen;
  logic [1:0] s_lvl;
  logic [AW-1:0] s_laddr, s_vaddr;
  logic [DW-1:0] s_lwdata, s_lmrdata, s_vrdata, s_vwdata;
  always_ff @(posedge clk) begin
    sync1_q <= {local_addr_strobe_n, vme_target_select_n, local_write, local_iack, local_addr,
      local_wdata, local_bus_grant_n, local_other_request_n, local_master_ack_n,
      local_master_rdata, vme_bus_clear_n, vme_dtack_n, vme_rdata, vme_slave_as_n,
      vme_slave_ds_n, vme_slave_select, vme_slave_write, vme_slave_addr, vme_slave_wdata,
      release_on_request, arbiter_bypass, fifo_coupled, rx_fifo_enable, request_level};
    sync2_q <= sync1_q;
  end
  assign {s_las_n, s_vsel_n, s_lwrite, s_liack, s_laddr, s_lwdata, s_lbg_n, s_oreq_n,
    s_lmack_n, s_lmrdata, s_bclr_n, s_dtack_n, s_vrdata, s_vas_n, s_vds_n, s_vsel,
    s_vwrite, s_vaddr, s_vwdata, s_ror, s_byp, s_fcpl, s_rxen, s_lvl} = sync2_q;

  // Local clock and arbiter rates (each one tick every 3 system clocks, 30 ns) as enables of the one system clock
  logic [1:0] ldiv_q, ldiv_d, adiv_q, adiv_d;
  logic local_tick, arb_tick;
  logic bg1_q, bg1_d, bg2_q, bg2_d, ia1_q, ia1_d, ia2_q, ia2_d;
  assign local_tick = (ldiv_q == 2'h0);
  assign arb_tick = (adiv_q == 2'h0);
  always_comb begin
    ldiv_d = local_tick ? LOCAL_DIV : ldiv_q - 2'h1;
    adiv_d = arb_tick ? ARB_DIV : adiv_q - 2'h1;
    bg1_d = arb_tick ? vme_bus_grant_in_n[s_lvl] : bg1_q;
    bg2_d = arb_tick ? bg1_q : bg2_q;
    ia1_d = arb_tick ? iack_in_n : ia1_q;
    ia2_d = arb_tick ? ia1_q : ia2_q;
  end
  always_ff @(posedge clk) begin
    if (reset) begin
      ldiv_q <= 2'h0;
      adiv_q <= 2'h0;
      bg1_q <= 1'b1;
      bg2_q <= 1'b1;
      ia1_q <= 1'b1;
      ia2_q <= 1'b1;
    end else begin
      ldiv_q <= ldiv_d;
      adiv_q <= adiv_d;
      bg1_q <= bg1_d;
      bg2_q <= bg2_d;
      ia1_q <= ia1_d;
      ia2_q <= ia2_d;
    end
  end
  assign iack_out_n = ia2_q;

  logic tx_in_valid, tx_in_ready, tx_out_valid, tx_out_ready;
  logic [XW-1:0] tx_out_data;
  logic rx_in_valid, rx_in_ready;
  vlcc_buffer #(.W(XW)) u_tx (.clk(clk), .reset(reset), .in_valid(tx_in_valid),
    .in_ready(tx_in_ready), .in_data({s_laddr, s_lwdata}), .out_valid(tx_out_valid),
    .out_ready(tx_out_ready), .out_data(tx_out_data));
  vlcc_buffer #(.W(XW)) u_rx (.clk(clk), .reset(reset), .in_valid(rx_in_valid),
    .in_ready(rx_in_ready), .in_data({s_vaddr, s_vwdata}), .out_valid(rx_valid),
    .out_ready(rx_ready), .out_data({rx_addr, rx_data}));

  // Master engine: local cycles out to the VMEbus
  vlcc_mst_t m_state_q, m_state_d;
  logic [3:0] m_lc_q, m_lc_d, m_ac_q, m_ac_d, gap_q, gap_d;
  logic owned_q, owned_d, breq_q, breq_d, as_q, as_d, cpl_q, cpl_d, lack_q, lack_d;
  logic vwr_q, vwr_d, start, dec_wr, cpl_done, las;
  logic [AW-1:0] vaddr_q, vaddr_d;
  logic [DW-1:0] vwdata_q, vwdata_d, lrdata_q, lrdata_d;
  assign las = !s_las_n;
  assign start = local_tick && las && !s_vsel_n && !lack_q;
  assign dec_wr = s_lwrite && !s_liack && !s_fcpl;
  always_comb begin
    m_state_d = m_state_q;
    m_lc_d = sat_inc(m_lc_q, local_tick);
    m_ac_d = sat_inc(m_ac_q, arb_tick);
    owned_d = owned_q;
    breq_d = breq_q;
    as_d = as_q;
    cpl_d = cpl_q;
    vwr_d = vwr_q;
    vaddr_d = vaddr_q;
    vwdata_d = vwdata_q;
    lrdata_d = lrdata_q;
    gap_d = sat_inc(gap_q, gap_q != DEC_GAP_CYC);
    tx_in_valid = m_state_q == M_IDLE && start && dec_wr;
    tx_out_ready = 1'b0;
    cpl_done = 1'b0;
    unique case (m_state_q)
      M_IDLE: begin
        if (tx_out_valid) begin
          if (!owned_q) begin
            cpl_d = 1'b0;
            m_ac_d = 4'h0;
            m_state_d = M_REQ;
          end else if (gap_q == DEC_GAP_CYC) begin
            // Next beat's address already waits in the buffer
            tx_out_ready = 1'b1;
            {vaddr_d, vwdata_d} = tx_out_data;
            vwr_d = 1'b1;
            as_d = 1'b1;
            // Launch cycle counts as the first of the beat
            gap_d = 4'h1;
            cpl_d = 1'b0;
            m_state_d = M_DRIVE;
          end
        end else if (start && !dec_wr) begin
          cpl_d = 1'b1;
          m_lc_d = 4'h0;
          m_state_d = M_DEC;
        end else if (owned_q && (!s_ror || !s_bclr_n)) begin
          owned_d = 1'b0;
        end
      end
      M_DEC: begin
        if (m_lc_q >= DEC_LTICKS) begin
          if (owned_q && s_ror) begin
            // Held bus skips arbitration entirely
            m_lc_d = ROR_PRELOAD;
            m_ac_d = 4'h0;
            m_state_d = M_SETUP;
          end else begin
            owned_d = 1'b0;
            m_ac_d = 4'h0;
            m_state_d = M_REQ;
          end
        end
      end
      M_REQ: begin
        if (m_ac_q >= REQ_ATICKS) begin
          breq_d = 1'b1;
          m_state_d = M_GNT;
        end
      end
      M_GNT: begin
        if (!bg2_q) begin
          owned_d = 1'b1;
          breq_d = 1'b0;
          m_lc_d = 4'h0;
          m_ac_d = 4'h0;
          m_state_d = M_SETUP;
        end
      end
      M_SETUP: begin
        if (m_lc_q >= SETUP_LTICKS && m_ac_q >= SETUP_ATICKS) begin
          as_d = 1'b1;
          gap_d = 4'h1;
          if (cpl_q) begin
            vaddr_d = s_laddr;
            vwdata_d = s_lwdata;
            vwr_d = s_lwrite;
          end else begin
            tx_out_ready = 1'b1;
            {vaddr_d, vwdata_d} = tx_out_data;
            vwr_d = 1'b1;
          end
          m_state_d = M_DRIVE;
        end
      end
      M_DRIVE: begin
        if (!s_dtack_n) begin
          as_d = 1'b0;
          if (cpl_q) begin
            lrdata_d = s_vrdata;
            cpl_done = 1'b1;
            m_state_d = M_TERM;
          end else begin
            m_state_d = M_IDLE;
          end
        end
      end
      M_TERM: begin
        if (!las && !lack_q) begin
          m_state_d = M_IDLE;
        end
      end
      default: m_state_d = M_IDLE;
    endcase
    lack_d = lack_q ? las : (cpl_done || (tx_in_valid && tx_in_ready));
  end
  always_ff @(posedge clk) begin
    if (reset) begin
      m_state_q <= M_IDLE;
      m_lc_q <= 4'h0;
      m_ac_q <= 4'h0;
      gap_q <= DEC_GAP_CYC;
      owned_q <= 1'b0;
      breq_q <= 1'b0;
      as_q <= 1'b0;
      cpl_q <= 1'b0;
      lack_q <= 1'b0;
      vwr_q <= 1'b0;
      vaddr_q <= '0;
      vwdata_q <= '0;
      lrdata_q <= '0;
    end else begin
      m_state_q <= m_state_d;
      m_lc_q <= m_lc_d;
      m_ac_q <= m_ac_d;
      gap_q <= gap_d;
      owned_q <= owned_d;
      breq_q <= breq_d;
      as_q <= as_d;
      cpl_q <= cpl_d;
      lack_q <= lack_d;
      vwr_q <= vwr_d;
      vaddr_q <= vaddr_d;
      vwdata_q <= vwdata_d;
      lrdata_q <= lrdata_d;
    end
  end
  assign local_data_ack_n = !lack_q;
  assign local_rdata = lrdata_q;
  assign vme_addr_strobe_pin_n = !as_q;
  assign vme_data_strobe_pin_n = !as_q;
  assign vme_write = vwr_q;
  assign vme_addr = vaddr_q;
  assign vme_wdata = vwdata_q;
  assign vme_bus_busy_n = !owned_q;
  assign vme_bus_request_n = ~({3'h0, breq_q} << s_lvl);
  // Own level is absorbed while requesting or holding the bus
  always_comb begin
    vme_bus_grant_out_n = vme_bus_grant_in_n;
    vme_bus_grant_out_n[s_lvl] = (breq_q || owned_q) ? 1'b1 : bg2_q;
  end

  // Slave engine and internal local arbiter
  vlcc_slv_t s_state_q, s_state_d;
  vlcc_arb_t arb_q, arb_d;
  logic [3:0] s_lc_q, s_lc_d, gcnt_q, gcnt_d;
  logic lreq_q, lreq_d, lmas_q, lmas_d, lmwr_q, lmwr_d, dtack_q, dtack_d, hit, lgnt;
  logic [AW-1:0] lmaddr_q, lmaddr_d;
  logic [DW-1:0] lmwdata_q, lmwdata_d, vsrd_q, vsrd_d;
  assign hit = !s_vas_n && !s_vds_n && s_vsel;
  assign lgnt = s_byp ? !s_lbg_n : (arb_q == ARB_SELF);
  always_comb begin
    s_state_d = s_state_q;
    s_lc_d = sat_inc(s_lc_q, local_tick);
    lreq_d = lreq_q;
    lmas_d = lmas_q;
    lmwr_d = lmwr_q;
    lmaddr_d = lmaddr_q;
    lmwdata_d = lmwdata_q;
    vsrd_d = vsrd_q;
    dtack_d = dtack_q;
    rx_in_valid = 1'b0;
    unique case (s_state_q)
      S_IDLE: begin
        if (hit && s_vwrite && s_rxen) begin
          rx_in_valid = 1'b1;
          dtack_d = rx_in_ready;
          s_state_d = rx_in_ready ? S_VACK : S_IDLE;
        end else if (hit) begin
          s_lc_d = 4'h0;
          s_state_d = S_DEC;
        end
      end
      S_DEC: begin
        if (s_lc_q >= SLV_DEC_LTICKS) begin
          lreq_d = 1'b1;
          s_state_d = S_LREQ;
        end
      end
      S_LREQ: begin
        if (lgnt) begin
          lmas_d = 1'b1;
          lmwr_d = s_vwrite;
          lmaddr_d = s_vaddr;
          lmwdata_d = s_vwdata;
          s_lc_d = 4'h0;
          s_state_d = S_LCYC;
        end
      end
      S_LCYC: begin
        // Same path for reads and writes keeps their timing equal
        if (!s_lmack_n && s_lc_q >= LCYC_LTICKS) begin
          lmas_d = 1'b0;
          vsrd_d = s_lmrdata;
          s_lc_d = 4'h0;
          s_state_d = S_POST;
        end
      end
      S_POST: begin
        if (s_lc_q >= (s_byp ? POST_BYP_LTICKS : POST_ACT_LTICKS)) begin
          lreq_d = 1'b0;
          dtack_d = 1'b1;
          s_state_d = S_VACK;
        end
      end
      S_VACK: begin
        if (s_vas_n || s_vds_n) begin
          dtack_d = 1'b0;
          s_state_d = S_IDLE;
        end
      end
      default: s_state_d = S_IDLE;
    endcase
  end
  always_comb begin
    arb_d = arb_q;
    gcnt_d = 4'h0;
    unique case (arb_q)
      ARB_NONE: begin
        if (lreq_q) begin
          gcnt_d = sat_inc(gcnt_q, local_tick);
          arb_d = (gcnt_q == ARB_GNT_LTICKS) ? ARB_SELF : ARB_NONE;
        end else if (!s_oreq_n) begin
          arb_d = ARB_OTHER;
        end
      end
      ARB_SELF: arb_d = lreq_q ? ARB_SELF : ARB_NONE;
      ARB_OTHER: arb_d = s_oreq_n ? ARB_NONE : ARB_OTHER;
      default: arb_d = ARB_NONE;
    endcase
    if (s_byp) begin
      arb_d = ARB_NONE;
    end
  end
  always_ff @(posedge clk) begin
    if (reset) begin
      s_state_q <= S_IDLE;
      arb_q <= ARB_NONE;
      s_lc_q <= 4'h0;
      gcnt_q <= 4'h0;
      lreq_q <= 1'b0;
      lmas_q <= 1'b0;
      lmwr_q <= 1'b0;
      dtack_q <= 1'b0;
      lmaddr_q <= '0;
      lmwdata_q <= '0;
      vsrd_q <= '0;
    end else begin
      s_state_q <= s_state_d;
      arb_q <= arb_d;
      s_lc_q <= s_lc_d;
      gcnt_q <= gcnt_d;
      lreq_q <= lreq_d;
      lmas_q <= lmas_d;
      lmwr_q <= lmwr_d;
      dtack_q <= dtack_d;
      lmaddr_q <= lmaddr_d;
      lmwdata_q <= lmwdata_d;
      vsrd_q <= vsrd_d;
    end
  end
  assign local_bus_request_n = !lreq_q;
  assign local_other_grant_n = (arb_q != ARB_OTHER);
  assign local_master_as_n = !lmas_q;
  assign local_master_write = lmwr_q;
  assign local_master_addr = lmaddr_q;
  assign local_master_wdata = lmwdata_q;
  assign vme_slave_dtack_n = !dtack_q;
  assign vme_slave_rdata = vsrd_q;

  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);
  AST_START_ON_TICK: assert property ((m_state_q == M_IDLE && m_state_d == M_DEC) |-> local_tick)
    else $error("coupled start off the local tick");
  AST_STROBE_OWNED: assert property (!vme_addr_strobe_pin_n |-> !vme_bus_busy_n)
    else $error("address strobe without bus ownership");
  AST_RWD_RELEASE: assert property ((m_state_q == M_IDLE && owned_q && !tx_out_valid && !s_ror
    && !start) |=> !owned_q)
    else $error("bus kept in release-when-done mode");
  AST_ROR_KEEP: assert property ((owned_q && s_ror && s_bclr_n && m_state_q != M_DEC) |=> owned_q)
    else $error("bus dropped without a clear request");
  AST_GAP: assert property (($fell(vme_addr_strobe_pin_n) && !cpl_q) |-> $past(gap_q) == DEC_GAP_CYC)
    else $error("decoupled strobes too close");
  AST_KEEP_TX: assert property ((owned_q && tx_out_valid) |=> owned_q)
    else $error("bus released with buffered writes");
  AST_HOLD_LOCAL: assert property ((m_state_q == M_DRIVE) |-> ##1 (local_data_ack_n || !cpl_q)
    or (!s_dtack_n ##0 1'b1))
    else $error("local cycle ended before VME cycle");
  AST_RX_ACK: assert property ((s_state_q == S_IDLE && hit && s_vwrite && s_rxen && rx_in_ready)
    |=> !vme_slave_dtack_n [*2])
    else $error("receive buffer write not acknowledged");
  AST_LGRANT: assert property ($rose(arb_q == ARB_SELF) |-> $past(gcnt_q) == ARB_GNT_LTICKS)
    else $error("local grant too early");
  AST_IACK_TICK: assert property ($changed(iack_out_n) |-> $past(arb_tick))
    else $error("acknowledge chain moved off the arbiter tick");
  AST_BG_PASS: assert property (vme_bus_grant_out_n[s_lvl + 2'h1] == vme_bus_grant_in_n[s_lvl + 2'h1])
    else $error("bus grant not passed through");
  AST_SLV_ORDER: assert property ($rose(dtack_q) && s_state_q == S_VACK && !s_rxen |-> !lreq_q)
    else $error("VME ended before local bus released");
  COV_ROR_FAST: cover property (m_state_q == M_DEC && m_state_d == M_SETUP);
  COV_RWD_ARB: cover property (m_state_q == M_GNT && m_state_d == M_SETUP && cpl_q);
  COV_DEC_WRITE: cover property (tx_out_ready && m_state_q == M_IDLE);
  COV_SLV_COUPLED: cover property (s_state_q == S_POST && s_state_d == S_VACK);
  COV_SLV_FIFO: cover property (rx_in_valid && !rx_in_ready);
endmodule

// file: hdl/vlcc_pkg.sv
package vlcc_pkg;
  localparam int CLK_PERIOD_NS = 10;
  localparam int LOCAL_CLK_NS = 30;
  localparam int ARB_CLK_PS = 31250;
  localparam logic [1:0] LOCAL_DIV = 2'(LOCAL_CLK_NS / CLK_PERIOD_NS - 1);
  localparam logic [1:0] ARB_DIV = 2'(ARB_CLK_PS / (CLK_PERIOD_NS * 1000) - 1);
  localparam int AW = 32;
  localparam int DW = 32;
  localparam int XW = AW + DW;
  localparam int SYNC_W = 211;
  // Master wait targets in local ticks and arbiter ticks
  localparam logic [3:0] DEC_LTICKS = 4'h3;
  localparam logic [3:0] REQ_ATICKS = 4'h3;
  localparam logic [3:0] SETUP_LTICKS = 4'h4;
  localparam logic [3:0] SETUP_ATICKS = 4'h3;
  localparam logic [3:0] ROR_PRELOAD = 4'h1;
  // Slave wait targets in local ticks; then write gap and receive ack time in ns and clocks, buffer depth
  localparam logic [3:0] SLV_DEC_LTICKS = 4'h3;
  localparam logic [3:0] ARB_GNT_LTICKS = 4'h4;
  localparam logic [3:0] LCYC_LTICKS = 4'h5;
  localparam logic [3:0] POST_ACT_LTICKS = 4'h3;
  localparam logic [3:0] POST_BYP_LTICKS = 4'h1;
  localparam int DEC_PERIOD_NS = 103;
  localparam logic [3:0] DEC_GAP_CYC = 4'((DEC_PERIOD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam int RX_ACK_NS = 56;
  localparam int RX_ACK_CYC = RX_ACK_NS / CLK_PERIOD_NS;
  localparam int BUF_DEPTH = 2;

  typedef enum logic [2:0] {
    M_IDLE = 3'h0, M_DEC = 3'h1, M_REQ = 3'h2, M_GNT = 3'h3,
    M_SETUP = 3'h4, M_DRIVE = 3'h5, M_TERM = 3'h6
  } vlcc_mst_t;
  typedef enum logic [2:0] {
    S_IDLE = 3'h0, S_DEC = 3'h1, S_LREQ = 3'h2, S_LCYC = 3'h3,
    S_POST = 3'h4, S_VACK = 3'h5
  } vlcc_slv_t;
  typedef enum logic [1:0] {
    ARB_NONE = 2'h0, ARB_SELF = 2'h1, ARB_OTHER = 2'h2
  } vlcc_arb_t;
endpackage
